/* File: src/asel_top.sv */
// Our own choices: the register addresses and strobed register access.
`timescale 1ns/10ps
`default_nettype none
`include "asel_params.svh"
module asel_top #(
	parameter int GATE_CYC   = `ASEL_GATE_CYC,
	parameter int SETTLE_CYC = `ASEL_SETTLE_CYC,
	parameter int TOL_HZ     = `ASEL_MATCH_TOL_HZ
) (
	input  wire logic                     ref_clk,
	input  wire logic                     srst,
	input  wire logic [7:0]               reg_addr,
	input  wire logic [31:0]              reg_wdata,
	input  wire logic                     reg_wr,
	input  wire logic                     reg_rd,
	output logic [31:0]                   reg_rdata,
	input  wire asel_pkg::asel_src_in_t   src_in,
	output logic                          sample_tick,
	output logic                          clk_slave,
	output asel_pkg::asel_src_t           active_reference_status,
	output asel_pkg::asel_state_vec_t     per_input_clock_state,
	output logic                          split_mode,
	output logic [16:0]                   link_rate,
	output logic                          irq
);
	// ========================================================
	// software registers
	logic [3:0]                  ctrl_q;
	logic [16:0]                 rate_q;
	logic [`ASEL_EV_W-1:0]       int_stat_q;
	logic [`ASEL_EV_W-1:0]       int_mask_q;
	logic [`ASEL_EV_W-1:0]       ev;
	logic [31:0]                 rdata_d;

	// ========================================================
	// source monitoring
	logic [2:0]                  valid;
	logic [2:0]                  usable;
	logic [16:0]                 freq [3];
	logic [16:0]                 target [3];
	logic [3:0]                  ticks;
	logic [26:0]                 acc_q;
	logic                        int_tick_q;
	asel_pkg::asel_src_t         sel_d;
	asel_pkg::asel_src_t         cur_sel;
	asel_pkg::asel_state_vec_t   state_d;
	logic                        sw_tick;
	logic                        split_d;
	logic                        auto_mode;
	asel_pkg::asel_src_t         pref;
	logic                        slave_prev_q;
	asel_pkg::asel_src_t         ref_prev_q;

	assign auto_mode = ctrl_q[`ASEL_CTRL_AUTO];
	assign pref      = asel_pkg::asel_src_t'(ctrl_q[`ASEL_CTRL_PREF_HI:`ASEL_CTRL_PREF_LO]);

	// measured rate within tolerance of the wanted rate
	function automatic logic rate_match(input logic [16:0] f, input logic [16:0] t);
		logic [16:0] diff;
		diff = (f > t) ? (f - t) : (t - f);
		rate_match = (diff <= 17'(TOL_HZ));
	endfunction : rate_match

	// reported state of one input from its meter and its sync line
	function automatic asel_pkg::asel_lock_t lock_state(input logic v, input logic s);
		if (!v) begin
			lock_state = asel_pkg::ASEL_NO_LOCK;
		end else if (s) begin
			lock_state = asel_pkg::ASEL_SYNC;
		end else begin
			lock_state = asel_pkg::ASEL_LOCK;
		end
	endfunction : lock_state

	// ========================================================
	// one meter per candidate input
	genvar gi;
	generate
		for (gi = 0; gi < 3; gi++) begin : g_src
			asel_freq_meter #(
				.GATE_CYC   (GATE_CYC),
				.SETTLE_CYC (SETTLE_CYC),
				.MIN_HZ     (`ASEL_MIN_HZ),
				.MAX_HZ     ((gi == 0) ? `ASEL_WC_MAX_HZ : `ASEL_MAX_HZ)
			) u_meter (
				.ref_clk (ref_clk),
				.srst    (srst),
				.lock    (src_in.lock[gi]),
				.tick    (src_in.tick[gi]),
				.valid_q (valid[gi]),
				.freq_q  (freq[gi])
			);
			// optical carries half rate while splitting
			assign target[gi] = (gi == 1 && split_d) ? (rate_q >> 1) : rate_q;
			assign usable[gi] = valid[gi] && rate_match(freq[gi], target[gi]);
		end
	endgenerate

	// ========================================================
	// split mode: auto select, double speed and optical preferred
	assign split_d = auto_mode && ctrl_q[`ASEL_CTRL_DBL]
		&& (pref == asel_pkg::ASEL_SRC_OPT);

	// ========================================================
	// reference selection
	always_comb begin
		logic [1:0] idx;
		sel_d = asel_pkg::ASEL_SRC_INT;
		idx   = 2'b00;
		if (auto_mode) begin
			if (pref != asel_pkg::ASEL_SRC_INT && usable[pref]) begin
				sel_d = pref;
			end else if (cur_sel != asel_pkg::ASEL_SRC_INT && usable[cur_sel]) begin
				sel_d = cur_sel;
			end else begin
				for (int k = 2; k >= 0; k--) begin
					idx = (pref == asel_pkg::ASEL_SRC_INT) ? 2'(k) : 2'((32'(pref) + 32'(k) + 1) % 3);
					if (usable[idx]) begin
						sel_d = asel_pkg::asel_src_t'(idx);
					end
				end
			end
		end
	end

	// internal crystal sample tick by phase accumulation
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			acc_q      <= 27'h000_0000;
			int_tick_q <= 1'b0;
		end else if (acc_q + 27'(link_rate) >= 27'(`ASEL_CLK_HZ)) begin
			acc_q      <= acc_q + 27'(link_rate) - 27'(`ASEL_CLK_HZ);
			int_tick_q <= 1'b1;
		end else begin
			acc_q      <= acc_q + 27'(link_rate);
			int_tick_q <= 1'b0;
		end
	end

	assign ticks = {int_tick_q, src_in.tick};

	asel_clk_switch u_switch (
		.ref_clk   (ref_clk),
		.srst      (srst),
		.tick_in   (ticks),
		.sel_req   (sel_d),
		.cur_sel_q (cur_sel),
		.tick_q    (sw_tick)
	);
	assign sample_tick             = sw_tick;
	assign active_reference_status = cur_sel;

	// ========================================================
	// per-input state
	always_comb begin
		state_d.wc    = lock_state(valid[0], src_in.sync[0]);
		state_d.opt   = lock_state(valid[1], src_in.sync[1]);
		state_d.spdif = lock_state(valid[2], src_in.sync[2]);
	end

	// registered status outputs
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			clk_slave             <= 1'b0;
			per_input_clock_state <= '{asel_pkg::ASEL_NO_LOCK, asel_pkg::ASEL_NO_LOCK, asel_pkg::ASEL_NO_LOCK};
			split_mode            <= 1'b0;
			link_rate             <= `ASEL_RATE_RST;
		end else begin
			clk_slave             <= (cur_sel != asel_pkg::ASEL_SRC_INT);
			per_input_clock_state <= state_d;
			split_mode            <= split_d;
			link_rate             <= split_d ? (rate_q >> 1) : rate_q;
		end
	end

	// ========================================================
	// event detection on status changes
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			slave_prev_q <= 1'b0;
			ref_prev_q   <= asel_pkg::ASEL_SRC_INT;
		end else begin
			slave_prev_q <= clk_slave;
			ref_prev_q   <= cur_sel;
		end
	end

	assign ev[`ASEL_EV_ORIGIN] = (clk_slave != slave_prev_q);
	assign ev[`ASEL_EV_REF]    = (cur_sel != ref_prev_q);
	assign ev[`ASEL_EV_SPLIT]  = (split_d != split_mode);
	assign ev[`ASEL_EV_STATE]  = (state_d != per_input_clock_state);

	// ========================================================
	// control registers
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			ctrl_q     <= `ASEL_CTRL_RST;
			rate_q     <= `ASEL_RATE_RST;
			int_mask_q <= `ASEL_MASK_RST;
		end else if (reg_wr) begin
			case (reg_addr)
				`ASEL_OFS_CTRL:     ctrl_q     <= reg_wdata[3:0];
				`ASEL_OFS_RATE:     rate_q     <= reg_wdata[16:0];
				`ASEL_OFS_INT_MASK: int_mask_q <= reg_wdata[`ASEL_EV_W-1:0];
				default:            ctrl_q     <= ctrl_q;
			endcase
		end
	end

	// sticky status, write one to clear; a new event wins over the clear
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			int_stat_q <= '0;
		end else if (reg_wr && reg_addr == `ASEL_OFS_INT_STAT) begin
			int_stat_q <= (int_stat_q & ~reg_wdata[`ASEL_EV_W-1:0]) | ev;
		end else begin
			int_stat_q <= int_stat_q | ev;
		end
	end

	// level interrupt
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			irq <= 1'b0;
		end else begin
			irq <= |(int_stat_q & int_mask_q);
		end
	end

	// ========================================================
	// read mux, data stands one cycle after the strobe
	always_comb begin
		rdata_d = 32'h0000_0000;
		case (reg_addr)
			`ASEL_OFS_CTRL:      rdata_d = {28'h000_0000, ctrl_q};
			`ASEL_OFS_STATUS:    rdata_d = {22'h00_0000, per_input_clock_state, split_mode, cur_sel, clk_slave};
			`ASEL_OFS_FREQ_REF:  rdata_d = (cur_sel == asel_pkg::ASEL_SRC_INT) ? {15'h0000, link_rate}
				: {15'h0000, freq[cur_sel]};
			`ASEL_OFS_FREQ_SPD:  rdata_d = {15'h0000, freq[2]};
			`ASEL_OFS_FREQ_OPT:  rdata_d = {15'h0000, freq[1]};
			`ASEL_OFS_INT_STAT:  rdata_d = {28'h000_0000, int_stat_q};
			`ASEL_OFS_INT_MASK:  rdata_d = {28'h000_0000, int_mask_q};
			`ASEL_OFS_RATE:      rdata_d = {15'h0000, rate_q};
			`ASEL_OFS_LINK_RATE: rdata_d = {15'h0000, link_rate};
			default:             rdata_d = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			reg_rdata <= 32'h0000_0000;
		end else if (reg_rd) begin
			reg_rdata <= rdata_d;
		end else begin
			reg_rdata <= 32'h0000_0000;
		end
	end
endmodule : asel_top
`default_nettype wire

/* File: src/asel_params.svh */
`ifndef ASEL_PARAMS_SVH
`define ASEL_PARAMS_SVH
// ==========================================================
// register offsets (byte addresses)
`define ASEL_OFS_CTRL      8'h00
`define ASEL_OFS_STATUS    8'h04
`define ASEL_OFS_FREQ_REF  8'h08
`define ASEL_OFS_FREQ_SPD  8'h0C
`define ASEL_OFS_FREQ_OPT  8'h10
`define ASEL_OFS_INT_STAT  8'h14
`define ASEL_OFS_INT_MASK  8'h18
`define ASEL_OFS_RATE      8'h1C
`define ASEL_OFS_LINK_RATE 8'h20
// ==========================================================
// control fields
`define ASEL_CTRL_AUTO     0
`define ASEL_CTRL_PREF_LO  1
`define ASEL_CTRL_PREF_HI  2
`define ASEL_CTRL_DBL      3
// status fields
`define ASEL_ST_SLAVE      0
`define ASEL_ST_REF_LO     1
`define ASEL_ST_REF_HI     2
`define ASEL_ST_SPLIT      3
`define ASEL_ST_STATE_LO   4
`define ASEL_ST_STATE_HI   9
// interrupt event bits
`define ASEL_EV_ORIGIN     0
`define ASEL_EV_REF        1
`define ASEL_EV_SPLIT      2
`define ASEL_EV_STATE      3
`define ASEL_EV_W          4
// ==========================================================
// reset values
`define ASEL_CTRL_RST      4'h0
`define ASEL_RATE_RST      17'h0_BB80
`define ASEL_MASK_RST      4'h0
// ==========================================================
// timing and ranges
`define ASEL_CLK_HZ        100000000
`define ASEL_GATE_US       10000
`define ASEL_SETTLE_US     1000
`define ASEL_GATE_CYC      (`ASEL_CLK_HZ / 1000000 * `ASEL_GATE_US)
`define ASEL_SETTLE_CYC    (`ASEL_CLK_HZ / 1000000 * `ASEL_SETTLE_US)
`define ASEL_HZ_PER_COUNT  (1000000 / `ASEL_GATE_US)
`define ASEL_MIN_HZ        28000
`define ASEL_MAX_HZ        103000
`define ASEL_WC_MAX_HZ     105000
`define ASEL_MATCH_TOL_HZ  500
`endif

/* File: src/asel_pkg.sv */
package asel_pkg;
	// clock sources; scan order is index order, starting after the preferred input
	typedef enum logic [1:0] {
		ASEL_SRC_WC    = 2'b00,
		ASEL_SRC_OPT   = 2'b01,
		ASEL_SRC_SPDIF = 2'b10,
		ASEL_SRC_INT   = 2'b11
	} asel_src_t;
	// per-input clock state
	typedef enum logic [1:0] {
		ASEL_NO_LOCK = 2'b00,
		ASEL_LOCK    = 2'b01,
		ASEL_SYNC    = 2'b10
	} asel_lock_t;
	typedef struct packed {
		asel_lock_t spdif;
		asel_lock_t opt;
		asel_lock_t wc;
	} asel_state_vec_t;
	typedef struct packed {
		logic [2:0] lock;
		logic [2:0] sync;
		logic [2:0] tick;
	} asel_src_in_t;
endpackage : asel_pkg

/* File: src/asel_freq_meter.sv */
`timescale 1ns/10ps
`default_nettype none
`include "asel_params.svh"
module asel_freq_meter #(
	parameter int GATE_CYC   = `ASEL_GATE_CYC,
	parameter int SETTLE_CYC = `ASEL_SETTLE_CYC,
	parameter int MIN_HZ     = `ASEL_MIN_HZ,
	parameter int MAX_HZ     = `ASEL_MAX_HZ
) (
	input  wire logic        ref_clk,
	input  wire logic        srst,
	input  wire logic        lock,
	input  wire logic        tick,
	output logic             valid_q,
	output logic [16:0]      freq_q
);
	logic [19:0] gate_q;
	logic [19:0] settle_q;
	logic [11:0] cnt_q;
	logic        whole_q;
	logic        gate_end;
	logic        stable;
	logic [31:0] meas;

	assign gate_end = (gate_q == 20'(GATE_CYC - 1));
	assign stable   = (settle_q == 20'(SETTLE_CYC));
	assign meas     = 32'(cnt_q) * 32'(`ASEL_HZ_PER_COUNT);

	// ========================================================
	// gate timer and tick count
	always_ff @(posedge ref_clk) begin
		if (srst || gate_end) begin
			gate_q <= 20'h0_0000;
			cnt_q  <= 12'h000;
		end else begin
			gate_q <= gate_q + 20'h0_0001;
			if (tick && cnt_q != 12'hFFF) begin
				cnt_q <= cnt_q + 12'h001;
			end
		end
	end

	// lock settle counter, restarts on any lock loss
	always_ff @(posedge ref_clk) begin
		if (srst || !lock) begin
			settle_q <= 20'h0_0000;
		end else if (!stable) begin
			settle_q <= settle_q + 20'h0_0001;
		end
	end

	// lock held over the whole gate
	always_ff @(posedge ref_clk) begin
		if (srst || gate_end) begin
			whole_q <= 1'b1;
		end else if (!lock) begin
			whole_q <= 1'b0;
		end
	end

	// result latched at gate end; validity drops at once on loss of lock
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			valid_q <= 1'b0;
			freq_q  <= 17'h0_0000;
		end else if (!lock) begin
			valid_q <= 1'b0;
		end else if (gate_end) begin
			freq_q  <= meas[16:0];
			valid_q <= stable && whole_q && lock
				&& meas >= 32'(MIN_HZ) && meas <= 32'(MAX_HZ);
		end
	end
endmodule : asel_freq_meter
`default_nettype wire

/* File: src/asel_clk_switch.sv */
`timescale 1ns/10ps
`default_nettype none
module asel_clk_switch (
	input  wire logic                 ref_clk,
	input  wire logic                 srst,
	input  wire logic [3:0]           tick_in,
	input  wire asel_pkg::asel_src_t  sel_req,
	output asel_pkg::asel_src_t       cur_sel_q,
	output logic                      tick_q
);
	typedef enum logic {
		ASEL_SW_RUN  = 1'b0,
		ASEL_SW_WAIT = 1'b1
	} asel_sw_t;
	asel_sw_t st_q;

	// ========================================================
	// a change takes effect only on a tick of the new source, so no short period
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			st_q      <= ASEL_SW_RUN;
			cur_sel_q <= asel_pkg::ASEL_SRC_INT;
			tick_q    <= 1'b0;
		end else begin
			case (st_q)
				ASEL_SW_RUN: begin
					if (sel_req != cur_sel_q) begin
						st_q   <= ASEL_SW_WAIT;
						tick_q <= 1'b0;
					end else begin
						tick_q <= tick_in[cur_sel_q];
					end
				end
				ASEL_SW_WAIT: begin
					if (tick_in[sel_req]) begin
						cur_sel_q <= sel_req;
						tick_q    <= 1'b1;
						st_q      <= ASEL_SW_RUN;
					end else begin
						tick_q <= 1'b0;
					end
				end
				default: begin
					st_q   <= ASEL_SW_RUN;
					tick_q <= 1'b0;
				end
			endcase
		end
	end
endmodule : asel_clk_switch
`default_nettype wire

/* File: sim/asel_src_model.sv */
`timescale 1ns/10ps
`default_nettype none
// ==========================================================
// far-side sources: word clock, optical, spdif
module asel_src_model (
	input  wire logic             ref_clk,
	input  wire logic [2:0]       en,
	input  wire logic [2:0]       sync_en,
	input  wire logic [11:0]      period,
	output asel_pkg::asel_src_in_t src_in
);
	logic [3:0] cnt_q [3];
	initial begin
		cnt_q = '{default: 4'h0};
		src_in = '0;
	end
	// one tick per period while enabled, lines low when off
	always @(posedge ref_clk) begin
		for (int i = 0; i < 3; i++) begin
			cnt_q[i] <= (cnt_q[i] + 4'h1 >= period[i*4 +: 4]) ? 4'h0 : cnt_q[i] + 4'h1;
			src_in.tick[i] <= en[i] && (cnt_q[i] == 4'h0);
			src_in.lock[i] <= en[i];
			src_in.sync[i] <= en[i] && sync_en[i];
		end
	end
endmodule : asel_src_model
`default_nettype wire

/* File: sim/asel_top_assertions.sv */
`timescale 1ns/10ps
`default_nettype none
`include "asel_params.svh"
module asel_top_assertions #(
	parameter int GATE_CYC   = 1000,
	parameter int SETTLE_CYC = 50,
	parameter int TOL_HZ     = 500
) (
	input wire logic                      ref_clk,
	input wire logic                      srst,
	input wire logic [7:0]                reg_addr,
	input wire logic [31:0]               reg_wdata,
	input wire logic                      reg_wr,
	input wire logic                      reg_rd,
	input wire logic [31:0]               reg_rdata,
	input wire asel_pkg::asel_src_in_t    src_in,
	input wire logic                      sample_tick,
	input wire logic                      clk_slave,
	input wire asel_pkg::asel_src_t       active_reference_status,
	input wire asel_pkg::asel_state_vec_t per_input_clock_state,
	input wire logic                      split_mode,
	input wire logic [16:0]               link_rate,
	input wire logic                      irq
);
	// ==========================================================
	// shadow of control, rate and mask writes
	logic [3:0]  ctrl_q;
	logic [16:0] rate_q;
	logic [3:0]  mask_q;
	logic [3:0]  age_q;
	logic [11:0] mwait_q;
	logic        split_exp;
	assign split_exp = ctrl_q[0] & ctrl_q[3] & (ctrl_q[2:1] == 2'h1);
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			ctrl_q <= 4'h0;
			rate_q <= `ASEL_RATE_RST;
			mask_q <= 4'h0;
		end else if (reg_wr) begin
			if (reg_addr == `ASEL_OFS_CTRL) ctrl_q <= reg_wdata[3:0];
			if (reg_addr == `ASEL_OFS_RATE) rate_q <= reg_wdata[16:0];
			if (reg_addr == `ASEL_OFS_INT_MASK) mask_q <= reg_wdata[3:0];
		end
	end
	// cycles since the last control or rate write
	always_ff @(posedge ref_clk) begin
		if (srst || (reg_wr && (reg_addr == `ASEL_OFS_CTRL || reg_addr == `ASEL_OFS_RATE))) age_q <= 4'h0;
		else if (age_q != 4'hF) age_q <= age_q + 4'h1;
	end
	// cycles spent in master mode while an input is still the reference
	always_ff @(posedge ref_clk) begin
		if (srst || ctrl_q[0] || active_reference_status == asel_pkg::ASEL_SRC_INT) mwait_q <= 12'h000;
		else if (mwait_q != 12'hFFF) mwait_q <= mwait_q + 12'h001;
	end
	// ==========================================================
	// properties
	default clocking @(posedge ref_clk); endclocking
	default disable iff (srst);
	sequence s_gone(logic l);
		(!l)[*3];
	endsequence
	a_slave_origin: assert property (!$past(srst)
		|-> clk_slave == ($past(active_reference_status) != asel_pkg::ASEL_SRC_INT)) else $error("slave flag wrong");
	a_rdata_idle: assert property (!reg_rd |=> reg_rdata == 32'h0000_0000)
		else $error("read data outside read slot");
	a_master_int: assert property (mwait_q < 12'hFA0)
		else $error("master mode not internal");
	a_split_cfg: assert property (age_q > 4'h3 |-> split_mode == split_exp)
		else $error("split mode wrong");
	a_link_rate: assert property (age_q > 4'h3
		|-> link_rate == (split_exp ? {1'b0, rate_q[16:1]} : rate_q)) else $error("link rate wrong");
	a_switch_clean: assert property (!$past(srst) && $changed(active_reference_status) |-> sample_tick)
		else $error("switch without tick");
	a_irq_masked: assert property (mask_q == 4'h0 && $past(mask_q) == 4'h0 |-> !irq)
		else $error("masked irq raised");
	a_wc_nolock: assert property (s_gone(src_in.lock[0])
		|-> per_input_clock_state.wc == asel_pkg::ASEL_NO_LOCK) else $error("wc state not cleared");
endmodule : asel_top_assertions
bind asel_top asel_top_assertions #(
	.GATE_CYC(GATE_CYC), .SETTLE_CYC(SETTLE_CYC), .TOL_HZ(TOL_HZ)
) asel_top_assertions_i (
	.ref_clk(ref_clk), .srst(srst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
	.reg_rd(reg_rd), .reg_rdata(reg_rdata), .src_in(src_in), .sample_tick(sample_tick), .clk_slave(clk_slave),
	.active_reference_status(active_reference_status), .per_input_clock_state(per_input_clock_state),
	.split_mode(split_mode), .link_rate(link_rate), .irq(irq)
);
`default_nettype wire

/* File: sim/asel_top_tb.sv */
`timescale 1ns/10ps
`default_nettype none
module asel_top_tb;
	typedef struct {
		logic [31:0] v;
		logic [31:0] tol;
	} asel_exp_t;
	localparam logic [31:0] R50K = 32'h0000_C350;
	localparam logic [31:0] R100K = 32'h0001_86A0;
	localparam logic [31:0] TOL = 32'h0000_00C8;
	logic                      ref_clk = 1'b0;
	logic                      srst = 1'b1;
	logic [7:0]                reg_addr = 8'h00;
	logic [31:0]               reg_wdata = 32'h0000_0000;
	logic                      reg_wr = 1'b0;
	logic                      reg_rd = 1'b0;
	logic                      rd_d = 1'b0;
	logic [2:0]                en = 3'h0;
	logic [2:0]                sync_en = 3'h1;
	logic [11:0]               period = 12'h444;
	logic [31:0]               reg_rdata;
	asel_pkg::asel_src_in_t    src_in;
	logic                      sample_tick;
	logic                      clk_slave;
	logic                      split_mode;
	logic                      irq;
	asel_pkg::asel_src_t       act_ref;
	asel_pkg::asel_state_vec_t states;
	logic [16:0]               link_rate;
	int                        n_fail = 0;
	int                        tests_run = 0;
	int                        cyc = 0;
	int                        seed = 32'h0000_4E93;
	logic [31:0]               p;
	asel_exp_t                 e;
	asel_exp_t                 exp_q[$];
	logic [7:0]                rst_a [8] = '{8'h00, 8'h04, 8'h08, 8'h14, 8'h18, 8'h1C, 8'h20, 8'h24};
	logic [31:0]               rst_v [8] = '{32'h0, 32'h6, 32'hBB80, 32'h0, 32'h0, 32'hBB80, 32'hBB80, 32'h0};
	// ==========================================================
	// design and far-side sources
	asel_top #(.GATE_CYC(2000), .SETTLE_CYC(50)) asel_top_i (
		.ref_clk(ref_clk), .srst(srst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_rdata(reg_rdata), .src_in(src_in), .sample_tick(sample_tick),
		.clk_slave(clk_slave), .active_reference_status(act_ref), .per_input_clock_state(states),
		.split_mode(split_mode), .link_rate(link_rate), .irq(irq)
	);
	asel_src_model asel_src_model_i (.ref_clk(ref_clk), .en(en), .sync_en(sync_en), .period(period), .src_in(src_in));
	initial forever #5 ref_clk = ~ref_clk;
	// ==========================================================
	// bus tasks and checks
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge ref_clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge ref_clk);
		reg_wr <= 1'b0;
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [31:0] v, input logic [31:0] t);
		exp_q.push_back('{v, t});
		@(posedge ref_clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge ref_clk);
		reg_rd <= 1'b0;
	endtask : rd
	// irq looked at two edges after the call, once it has settled
	task automatic chk(input logic x);
		repeat (2) @(posedge ref_clk);
		#1;
		tests_run++;
		if (irq !== x) begin
			n_fail++;
			$display("[ERR] %0t exp %h got %h", $time, x, irq);
		end
	endtask : chk
	// sample strobes counted over 600 cycles, one either way allowed for phase
	task automatic tick_chk(input int want);
		int n;
		n = 0;
		repeat (600) begin
			@(posedge ref_clk);
			if (sample_tick === 1'b1) n++;
		end
		tests_run++;
		if (n < want - 1 || n > want + 1) begin
			n_fail++;
			$display("[ERR] %0t exp %h got %h", $time, want, n);
		end
	endtask : tick_chk
	task automatic settle;
		repeat (6000) @(posedge ref_clk);
	endtask : settle
	task automatic done(input string s);
		$display("test %s done", s);
	endtask : done
	function automatic logic [31:0] st(input logic sl, input logic [1:0] rf, input logic sp, input logic [5:0] s);
		return {22'h00_0000, s, sp, rf, sl};
	endfunction : st
	task automatic results;
		$display("checks %0d mismatches %0d", tests_run, n_fail);
		if (n_fail == 0 && tests_run > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask : results
	// read data checked in its slot against the oldest note
	always @(posedge ref_clk) begin
		rd_d <= reg_rd;
		cyc++;
		if (rd_d) begin
			e = exp_q.pop_front();
			tests_run++;
			if (((reg_rdata + e.tol >= e.v) && (reg_rdata <= e.v + e.tol)) !== 1'b1) begin
				n_fail++;
				$display("[ERR] %0t exp %h got %h", $time, e.v, reg_rdata);
			end
		end
		if (cyc == 90000) begin
			n_fail++;
			results();
		end
	end
	// ==========================================================
	// scenarios
	initial begin
		repeat (10) @(posedge ref_clk);
		srst <= 1'b0;
		wr(8'h24, 32'hFFFF_FFFF);
		for (int i = 0; i < 8; i++) rd(rst_a[i], rst_v[i], 32'h0);
		done("reset");
		wr(8'h18, 32'h0000_000F);
		wr(8'h1C, R50K);
		en <= 3'h7;
		settle();
		rd(8'h04, st(1'b0, 2'h3, 1'b0, 6'h16), 32'h0);
		rd(8'h0C, R50K, TOL);
		rd(8'h10, R50K, TOL);
		rd(8'h20, R50K, 32'h0);
		chk(1'b1);
		wr(8'h14, 32'h0000_000F);
		chk(1'b0);
		done("master");
		wr(8'h00, 32'h0000_0007);
		settle();
		rd(8'h04, st(1'b1, 2'h0, 1'b0, 6'h16), 32'h0);
		rd(8'h08, R50K, TOL);
		wr(8'h00, 32'h0000_0005);
		settle();
		rd(8'h04, st(1'b1, 2'h2, 1'b0, 6'h16), 32'h0);
		en <= 3'h3;
		settle();
		rd(8'h04, st(1'b1, 2'h0, 1'b0, 6'h06), 32'h0);
		period <= 12'h454;
		en <= 3'h2;
		settle();
		rd(8'h04, st(1'b0, 2'h3, 1'b0, 6'h04), 32'h0);
		wr(8'h18, 32'h0000_0000);
		wr(8'h14, 32'h0000_000F);
		done("select");
		period <= 12'h444;
		en <= 3'h1;
		settle();
		chk(1'b0);
		rd(8'h14, 32'h0000_000B, 32'h0);
		wr(8'h18, 32'h0000_0001);
		chk(1'b1);
		wr(8'h14, 32'h0000_0001);
		chk(1'b0);
		done("interrupt");
		wr(8'h1C, R100K);
		period <= 12'h242;
		en <= 3'h7;
		wr(8'h00, 32'h0000_000B);
		settle();
		rd(8'h04, st(1'b1, 2'h1, 1'b1, 6'h16), 32'h0);
		rd(8'h20, R50K, 32'h0);
		rd(8'h0C, R100K, TOL);
		rd(8'h10, R50K, TOL);
		done("split");
		for (int k = 0; k < 2; k++) begin
			p = 32'h0000_0003 + ($unsigned($random(seed)) % 32'h0000_0004);
			period <= {8'h44, p[3:0]};
			en <= 3'h1;
			wr(8'h1C, 32'h0003_0D40 / p);
			wr(8'h00, 32'h0000_0001);
			settle();
			rd(8'h04, st(1'b1, 2'h0, 1'b0, 6'h02), 32'h0);
			rd(8'h08, 32'h0003_0D40 / p, TOL);
			tick_chk(600 / p);
		end
		done("varispeed");
		wr(8'h00, 32'h0000_0000);
		settle();
		rd(8'h04, st(1'b0, 2'h3, 1'b0, 6'h02), 32'h0);
		done("master again");
		repeat (3) @(posedge ref_clk);
		results();
	end
endmodule : asel_top_tb
`default_nettype wire
